// ===== hdl/umbc_phase_acc.sv
// phase accumulator that turns the baud phase value into baud ticks
`timescale 1ns/1ps
module umbc_phase_acc #(
  parameter int WIDTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] phase,
  output logic tick
);
  import umbc_pkg::*;

  logic [WIDTH-1:0] acc_q;
  logic tick_q;
  logic [WIDTH:0] sum;

  assign sum = {1'b0, acc_q} + {1'b0, phase};

  // add the phase every system clock, tick on each carry out
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= '0;
      tick_q <= 1'b0;
    end else begin
      acc_q <= sum[WIDTH-1:0];
      tick_q <= sum[WIDTH];
    end
  end

  assign tick = tick_q;
endmodule

// ===== hdl/umbc_rate_div.sv
// final bit-rate divider: 16/64 of baud ticks or 32/64 of the system clock
`timescale 1ns/1ps
`include "umbc_defs.svh"
module umbc_rate_div #(
  parameter int CNT_W = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic baud_tick,
  input wire logic use_sys_clk,
  input wire logic fast_sel,
  input wire logic run,
  output logic bit_en
);
  import umbc_pkg::*;

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] last;
  logic step;
  logic bit_en_q;

  always_comb begin
    if (use_sys_clk) begin
      last = fast_sel ? CNT_W'(`UMBC_DIV_SYS_FAST - 1) : CNT_W'(`UMBC_DIV_SYS_SLOW - 1);
    end else begin
      last = fast_sel ? CNT_W'(`UMBC_DIV_BAUD_FAST - 1) : CNT_W'(`UMBC_DIV_BAUD_SLOW - 1);
    end
  end

  assign step = run && (use_sys_clk || baud_tick);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      bit_en_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= '0;
      bit_en_q <= 1'b0;
    end else begin
      bit_en_q <= step && (cnt_q >= last);
      if (step) begin
        cnt_q <= (cnt_q >= last) ? '0 : cnt_q + 1'b1;
      end
    end
  end

  assign bit_en = bit_en_q;
endmodule

// ===== hdl/umbc_uart1_cfg.sv
// mode and baud configuration slice of serial port 1 with its register bus slave
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "umbc_defs.svh"
module umbc_uart1_cfg (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic [`UMBC_ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [`UMBC_DATA_W-1:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [`UMBC_ADDR_W-1:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [`UMBC_DATA_W-1:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic MODE_BIT_ONE,
  input wire logic RX_DONE_FLAG,
  input wire logic TX_DONE_FLAG,
  input wire logic STOP_BIT_INVALID,
  output logic MODE_BIT_ZERO,
  output logic FRAMING_DETECT_SELECT,
  output logic BAUD_DIVIDER_SELECT,
  output logic FRAMING_ERROR_FLAG,
  output logic SERIAL_IRQ_REQ,
  output umbc_pkg::umbc_phase_type BAUD_PHASE,
  output logic BAUD_TICK,
  output logic BIT_RATE_EN,
  output logic IRQ
);
  import umbc_pkg::*;

  // word index of a byte address
  function automatic logic [5:0] word_idx(input logic [`UMBC_ADDR_W-1:0] a);
    word_idx = a[`UMBC_ADDR_W-1:2];
  endfunction

  // true for an address that hits one of the five words
  function automatic logic is_mapped(input logic [`UMBC_ADDR_W-1:0] a);
    logic [5:0] w;
    w = a[`UMBC_ADDR_W-1:2];
    is_mapped = (w == `UMBC_SMC_IDX) || (w == `UMBC_BPV_IDX) || (w == `UMBC_CTL7_IDX)
      || (w == `UMBC_STAT_IDX) || (w == `UMBC_MASK_IDX);
  endfunction

  // byte-lane merge of new data into an old byte
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                      input logic en);
    lane = en ? nw : old;
  endfunction

  // bus side state
  umbc_wr_state_type wr_state_q;
  umbc_rd_state_type rd_state_q;
  logic aw_held_q;
  logic [`UMBC_ADDR_W-1:0] aw_addr_q;
  logic w_held_q;
  logic [`UMBC_DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  logic [1:0] bresp_q;
  logic [`UMBC_DATA_W-1:0] rdata_q;
  logic [1:0] rresp_q;
  logic [`UMBC_DATA_W-1:0] rd_word;

  // configuration and status state
  logic [7:0] smc_q;
  umbc_phase_type bpv_q;
  logic mode0_q;
  logic fe_q;
  logic [2:0] stat_q;
  logic [2:0] mask_q;
  logic rx_prev_q;
  logic tx_prev_q;

  // decoded write strobes
  logic do_write;
  logic [5:0] wr_idx;
  logic wr_smc;
  logic wr_bpv;
  logic wr_ctl7;
  logic wr_stat;
  logic wr_mask;
  logic fe_set;
  logic [2:0] ev;
  logic fds;
  logic mode2;
  logic mode13;
  logic baud_tick;

  // ---------------- write channel ----------------
  assign S_AXI_AWREADY = !aw_held_q && (wr_state_q == UMBC_W_IDLE);
  assign S_AXI_WREADY = !w_held_q && (wr_state_q == UMBC_W_IDLE);
  assign S_AXI_BVALID = (wr_state_q == UMBC_W_RESP);
  assign S_AXI_BRESP = bresp_q;

  assign do_write = aw_held_q && w_held_q && (wr_state_q == UMBC_W_IDLE);
  assign wr_idx = word_idx(aw_addr_q);
  assign wr_smc = do_write && (wr_idx == `UMBC_SMC_IDX);
  assign wr_bpv = do_write && (wr_idx == `UMBC_BPV_IDX);
  assign wr_ctl7 = do_write && (wr_idx == `UMBC_CTL7_IDX) && w_strb_q[0];
  assign wr_stat = do_write && (wr_idx == `UMBC_STAT_IDX) && w_strb_q[0];
  assign wr_mask = do_write && (wr_idx == `UMBC_MASK_IDX) && w_strb_q[0];

  // address and data may arrive in either order; each is held until the write
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (S_AXI_AWVALID && S_AXI_AWREADY) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= S_AXI_AWADDR;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      w_held_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else if (S_AXI_WVALID && S_AXI_WREADY) begin
      w_held_q <= 1'b1;
      w_data_q <= S_AXI_WDATA;
      w_strb_q <= S_AXI_WSTRB;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      wr_state_q <= UMBC_W_IDLE;
      bresp_q <= `UMBC_RESP_OKAY;
    end else begin
      case (wr_state_q)
        UMBC_W_IDLE: begin
          if (do_write) begin
            wr_state_q <= UMBC_W_RESP;
            bresp_q <= is_mapped(aw_addr_q) ? `UMBC_RESP_OKAY : `UMBC_RESP_SLVERR;
          end
        end
        UMBC_W_RESP: begin
          if (S_AXI_BREADY) begin
            wr_state_q <= UMBC_W_IDLE;
          end
        end
        default: begin
          wr_state_q <= UMBC_W_IDLE;
        end
      endcase
    end
  end

  // ---------------- read channel ----------------
  assign S_AXI_ARREADY = (rd_state_q == UMBC_R_IDLE);
  assign S_AXI_RVALID = (rd_state_q == UMBC_R_DATA);
  assign S_AXI_RDATA = rdata_q;
  assign S_AXI_RRESP = rresp_q;

  always_comb begin
    rd_word = '0;
    case (word_idx(S_AXI_ARADDR))
      `UMBC_SMC_IDX: rd_word[7:0] = smc_q & `UMBC_SMC_WMASK;
      `UMBC_BPV_IDX: rd_word[15:0] = bpv_q;
      `UMBC_CTL7_IDX: rd_word[0] = fds ? fe_q : mode0_q;
      `UMBC_STAT_IDX: rd_word[2:0] = stat_q;
      `UMBC_MASK_IDX: rd_word[2:0] = mask_q;
      default: rd_word = '0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rd_state_q <= UMBC_R_IDLE;
      rdata_q <= '0;
      rresp_q <= `UMBC_RESP_OKAY;
    end else begin
      case (rd_state_q)
        UMBC_R_IDLE: begin
          if (S_AXI_ARVALID) begin
            rd_state_q <= UMBC_R_DATA;
            rdata_q <= rd_word;
            rresp_q <= is_mapped(S_AXI_ARADDR) ? `UMBC_RESP_OKAY : `UMBC_RESP_SLVERR;
          end
        end
        UMBC_R_DATA: begin
          if (S_AXI_RREADY) begin
            rd_state_q <= UMBC_R_IDLE;
          end
        end
        default: begin
          rd_state_q <= UMBC_R_IDLE;
        end
      endcase
    end
  end

  // ---------------- mode configuration ----------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      smc_q <= `UMBC_SMC_RESET;
    end else if (wr_smc && w_strb_q[0]) begin
      smc_q <= w_data_q[7:0] & `UMBC_SMC_WMASK;
    end
  end

  assign fds = smc_q[`UMBC_FDS_BIT];

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      bpv_q <= `UMBC_BPV_RESET;
    end else if (wr_bpv) begin
      bpv_q[7:0] <= lane(bpv_q[7:0], w_data_q[7:0], w_strb_q[0]);
      bpv_q[15:8] <= lane(bpv_q[15:8], w_data_q[15:8], w_strb_q[1]);
    end
  end

  // control bit 7: mode bit zero, or the framing error flag
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode0_q <= 1'b0;
    end else if (wr_ctl7 && !fds) begin
      mode0_q <= w_data_q[0];
    end
  end

  assign fe_set = fds && STOP_BIT_INVALID;

  // set wins over a software clear in the same cycle; writing one has no effect
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fe_q <= 1'b0;
    end else if (fe_set) begin
      fe_q <= 1'b1;
    end else if (wr_ctl7 && fds && !w_data_q[0]) begin
      fe_q <= 1'b0;
    end
  end

  // ---------------- events and interrupt ----------------
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rx_prev_q <= 1'b0;
      tx_prev_q <= 1'b0;
    end else begin
      rx_prev_q <= RX_DONE_FLAG;
      tx_prev_q <= TX_DONE_FLAG;
    end
  end

  assign ev[`UMBC_EV_RX] = RX_DONE_FLAG && !rx_prev_q;
  assign ev[`UMBC_EV_TX] = TX_DONE_FLAG && !tx_prev_q;
  assign ev[`UMBC_EV_FE] = fe_set;

  // write one to clear; a new event in the same cycle keeps the bit set
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      stat_q <= `UMBC_EVT_RESET;
    end else begin
      stat_q <= ev | (stat_q & ~(wr_stat ? w_data_q[2:0] : 3'h0));
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_q <= `UMBC_EVT_RESET;
    end else if (wr_mask) begin
      mask_q <= w_data_q[2:0];
    end
  end

  assign IRQ = |(stat_q & mask_q);
  assign SERIAL_IRQ_REQ = smc_q[`UMBC_SIE_BIT] && (RX_DONE_FLAG || TX_DONE_FLAG);

  // ---------------- baud generation ----------------
  assign mode2 = mode0_q && !MODE_BIT_ONE;
  assign mode13 = MODE_BIT_ONE;

  umbc_phase_acc #(
    .WIDTH(16)
  ) u_acc (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .phase(bpv_q),
    .tick(baud_tick)
  );

  umbc_rate_div #(
    .CNT_W(6)
  ) u_div (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .baud_tick(baud_tick),
    .use_sys_clk(mode2),
    .fast_sel(smc_q[`UMBC_BDS_BIT]),
    .run(mode2 || mode13),
    .bit_en(BIT_RATE_EN)
  );

  assign BAUD_TICK = baud_tick;
  assign BAUD_PHASE = bpv_q;
  assign MODE_BIT_ZERO = mode0_q;
  assign FRAMING_DETECT_SELECT = fds;
  assign BAUD_DIVIDER_SELECT = smc_q[`UMBC_BDS_BIT];
  assign FRAMING_ERROR_FLAG = fe_q;

endmodule

// ===== pkg/umbc_defs.svh
// register map, field positions, reset values and divider counts of the mode/baud slice
`ifndef UMBC_DEFS_SVH
`define UMBC_DEFS_SVH

`define UMBC_ADDR_W 8
`define UMBC_DATA_W 32

// word indices; byte address is four times the index
`define UMBC_SMC_IDX 6'h08
`define UMBC_BPV_IDX 6'h09
`define UMBC_CTL7_IDX 6'h0a
`define UMBC_STAT_IDX 6'h0b
`define UMBC_MASK_IDX 6'h0c

`define UMBC_SMC_RESET 8'h00
`define UMBC_BPV_RESET 16'h0000
`define UMBC_EVT_RESET 3'h0
`define UMBC_SMC_WMASK 8'h07

`define UMBC_FDS_BIT 0
`define UMBC_BDS_BIT 1
`define UMBC_SIE_BIT 2

`define UMBC_EV_RX 0
`define UMBC_EV_TX 1
`define UMBC_EV_FE 2
`define UMBC_EV_W 3

`define UMBC_DIV_BAUD_FAST 16
`define UMBC_DIV_BAUD_SLOW 64
`define UMBC_DIV_SYS_FAST 32
`define UMBC_DIV_SYS_SLOW 64

`define UMBC_RESP_OKAY 2'b00
`define UMBC_RESP_SLVERR 2'b10

`endif

// ===== pkg/umbc_pkg.sv
// types shared by the mode/baud configuration slice
package umbc_pkg;

  typedef enum logic [0:0] {
    UMBC_W_IDLE = 1'b0,
    UMBC_W_RESP = 1'b1
  } umbc_wr_state_type;

  typedef enum logic [0:0] {
    UMBC_R_IDLE = 1'b0,
    UMBC_R_DATA = 1'b1
  } umbc_rd_state_type;

  typedef logic [15:0] umbc_phase_type;

endpackage

// ===== verif/test_umbc_uart1_cfg.sv
// self-checking bench of the mode/baud configuration slice
`timescale 1ns/1ps
module test_umbc_uart1_cfg;
  logic SYS_CLK, RST_N, S_AXI_AWVALID, S_AXI_AWREADY, S_AXI_WVALID, S_AXI_WREADY;
  logic S_AXI_BVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_ARREADY, S_AXI_RVALID, S_AXI_RREADY;
  logic [7:0] S_AXI_AWADDR, S_AXI_ARADDR;
  logic [31:0] S_AXI_WDATA, S_AXI_RDATA;
  logic [3:0] S_AXI_WSTRB;
  logic [1:0] S_AXI_BRESP, S_AXI_RRESP;
  logic MODE_BIT_ONE, RX_DONE_FLAG, TX_DONE_FLAG, STOP_BIT_INVALID, MODE_BIT_ZERO, IRQ;
  logic FRAMING_DETECT_SELECT, BAUD_DIVIDER_SELECT, FRAMING_ERROR_FLAG, SERIAL_IRQ_REQ;
  logic BAUD_TICK, BIT_RATE_EN;
  umbc_pkg::umbc_phase_type BAUD_PHASE;
  int n_errors = 0;
  int comparisons = 0;
  always #50 SYS_CLK = ~SYS_CLK;
  umbc_uart1_cfg u_dut (.SYS_CLK, .RST_N, .S_AXI_AWADDR, .S_AXI_AWVALID, .S_AXI_AWREADY,
    .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BRESP, .S_AXI_BVALID,
    .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID, .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP,
    .S_AXI_RVALID, .S_AXI_RREADY, .MODE_BIT_ONE, .RX_DONE_FLAG, .TX_DONE_FLAG,
    .STOP_BIT_INVALID, .MODE_BIT_ZERO, .FRAMING_DETECT_SELECT, .BAUD_DIVIDER_SELECT,
    .FRAMING_ERROR_FLAG, .SERIAL_IRQ_REQ, .BAUD_PHASE, .BAUD_TICK, .BIT_RATE_EN, .IRQ);
  umbc_serial_peer u_peer (.clk(SYS_CLK), .mode_one(MODE_BIT_ONE), .rx_done(RX_DONE_FLAG),
    .tx_done(TX_DONE_FLAG), .bad_stop(STOP_BIT_INVALID));
  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic hang();
    n_errors++;
    summarize();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    int i;
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= d;
    S_AXI_AWVALID <= 1'h1;
    S_AXI_WVALID <= 1'h1;
    S_AXI_BREADY <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge SYS_CLK);
      if (S_AXI_AWREADY) S_AXI_AWVALID <= 1'h0;
      if (S_AXI_WREADY) S_AXI_WVALID <= 1'h0;
      if (S_AXI_BVALID) break;
    end
    if (i == 40) hang();
    chk("bresp", S_AXI_BRESP, r);
    S_AXI_BREADY <= 1'h0;
    @(posedge SYS_CLK);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = 2'h0);
    int i;
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'h1;
    S_AXI_RREADY <= 1'h1;
    for (i = 0; i < 40; i++) begin
      @(posedge SYS_CLK);
      if (S_AXI_ARREADY) S_AXI_ARVALID <= 1'h0;
      if (S_AXI_RVALID) break;
    end
    if (i == 40) hang();
    chk("rdata", S_AXI_RDATA, e);
    chk("rresp", S_AXI_RRESP, r);
    S_AXI_RREADY <= 1'h0;
    @(posedge SYS_CLK);
  endtask
  // second of two pulse gaps, the first may be a partial count
  task automatic gap(input int e);
    int i, n;
    for (i = 0; i < 600 && BIT_RATE_EN !== 1'h1; i++) @(posedge SYS_CLK);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge SYS_CLK);
        n++;
      end while (BIT_RATE_EN !== 1'h1 && n < 600);
    end
    if (n >= 600 || i >= 600) hang();
    chk("gap", n, e);
  endtask
  task automatic t_reset();
    rd(8'h20, 32'h0);
    rd(8'h24, 32'h0);
    chk("fds", FRAMING_DETECT_SELECT, 32'h0);
    chk("phase", BAUD_PHASE, 32'h0);
    $display("reset test done");
  endtask
  task automatic t_regs();
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h7);
    chk("bds", BAUD_DIVIDER_SELECT, 32'h1);
    wr(8'h24, 32'h1234abcd);
    rd(8'h24, 32'habcd);
    wr(8'h3c, 32'h5, 2'h2);
    rd(8'h3c, 32'h0, 2'h2);
    $display("register test done");
  endtask
  task automatic t_irq();
    wr(8'h20, 32'h0);
    u_peer.flags(1'h0, 1'h1, 1'h0);
    chk("irq_req", SERIAL_IRQ_REQ, 32'h0);
    wr(8'h20, 32'h4);
    chk("irq_req", SERIAL_IRQ_REQ, 32'h1);
    rd(8'h2c, 32'h1);
    chk("irq", IRQ, 32'h0);
    wr(8'h30, 32'h1);
    chk("irq", IRQ, 32'h1);
    wr(8'h2c, 32'h1);
    chk("irq", IRQ, 32'h0);
    u_peer.flags(1'h0, 1'h0, 1'h1);
    rd(8'h2c, 32'h2);
    u_peer.flags(1'h0, 1'h0, 1'h0);
    chk("irq_req", SERIAL_IRQ_REQ, 32'h0);
    $display("interrupt test done");
  endtask
  task automatic t_fe();
    wr(8'h28, 32'h1);
    chk("mode0", MODE_BIT_ZERO, 32'h1);
    wr(8'h20, 32'h1);
    wr(8'h28, 32'h0);
    chk("mode0", MODE_BIT_ZERO, 32'h1);
    rd(8'h28, 32'h0);
    u_peer.bad_frame();
    chk("fe", FRAMING_ERROR_FLAG, 32'h1);
    rd(8'h28, 32'h1);
    wr(8'h28, 32'h1);
    chk("fe", FRAMING_ERROR_FLAG, 32'h1);
    wr(8'h28, 32'h0);
    chk("fe", FRAMING_ERROR_FLAG, 32'h0);
    $display("framing test done");
  endtask
  task automatic t_rate();
    wr(8'h24, 32'h8000);
    wr(8'h20, 32'h3);
    gap(32);
    wr(8'h20, 32'h1);
    gap(64);
    wr(8'h24, 32'h4000);
    u_peer.flags(1'h1, 1'h0, 1'h0);
    wr(8'h20, 32'h3);
    gap(64);
    wr(8'h20, 32'h1);
    gap(256);
    $display("rate test done");
  endtask
  initial begin
    SYS_CLK = 1'h0;
    RST_N = 1'h0;
    {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY, S_AXI_ARVALID, S_AXI_RREADY} = 5'h00;
    S_AXI_AWADDR = 8'h00;
    S_AXI_ARADDR = 8'h00;
    S_AXI_WDATA = 32'h0;
    S_AXI_WSTRB = 4'hf;
    repeat (16) @(posedge SYS_CLK);
    RST_N <= 1'h1;
    @(posedge SYS_CLK);
    t_reset();
    t_regs();
    RST_N <= 1'h0;
    repeat (16) @(posedge SYS_CLK);
    RST_N <= 1'h1;
    @(posedge SYS_CLK);
    t_reset();
    t_irq();
    t_fe();
    t_rate();
    summarize();
  end
endmodule

// ===== verif/umbc_cfg_sva.sv
// concurrent checks on the ports of the mode/baud slice
`timescale 1ns/1ps
module umbc_cfg_sva (
  input wire logic SYS_CLK,
  input wire logic RST_N,
  input wire logic S_AXI_BVALID,
  input wire logic MODE_BIT_ONE,
  input wire logic RX_DONE_FLAG,
  input wire logic TX_DONE_FLAG,
  input wire logic STOP_BIT_INVALID,
  input wire logic MODE_BIT_ZERO,
  input wire logic FRAMING_DETECT_SELECT,
  input wire logic BAUD_DIVIDER_SELECT,
  input wire logic FRAMING_ERROR_FLAG,
  input wire logic SERIAL_IRQ_REQ,
  input wire umbc_pkg::umbc_phase_type BAUD_PHASE,
  input wire logic BAUD_TICK,
  input wire logic BIT_RATE_EN
);
  import umbc_pkg::*;
  logic [6:0] gap_q;
  logic ok_q;
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // cycles since last bit-rate pulse, trusted only in steady mode 2
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gap_q <= 7'h00;
      ok_q <= 1'h0;
    end else begin
      gap_q <= BIT_RATE_EN ? 7'h01 : gap_q + 7'h01;
      ok_q <= (BIT_RATE_EN | ok_q) & MODE_BIT_ZERO & !MODE_BIT_ONE & $stable(BAUD_DIVIDER_SELECT);
    end
  end
  // the pulse was timed with the divider select seen one edge earlier
  property p_rate_sys;
    BIT_RATE_EN && ok_q |-> gap_q == ($past(BAUD_DIVIDER_SELECT) ? 7'h20 : 7'h40);
  endproperty
  a_rate_sys: assert property (p_rate_sys) else $error("bit rate gap wrong");
  property p_irq_req;
    SERIAL_IRQ_REQ |-> RX_DONE_FLAG || TX_DONE_FLAG;
  endproperty
  a_irq_req: assert property (p_irq_req) else $error("irq request without flag");
  // with steady flags the request may only move when a register write completes
  property p_irq_hold;
    $stable(RX_DONE_FLAG) && $stable(TX_DONE_FLAG) && !$rose(S_AXI_BVALID)
      |-> $stable(SERIAL_IRQ_REQ);
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq request moved alone");
  property p_fe_set;
    FRAMING_DETECT_SELECT && STOP_BIT_INVALID |=> FRAMING_ERROR_FLAG;
  endproperty
  a_fe_set: assert property (p_fe_set) else $error("framing flag not set");
  property p_fe_clear;
    $fell(FRAMING_ERROR_FLAG) |-> $rose(S_AXI_BVALID);
  endproperty
  a_fe_clear: assert property (p_fe_clear) else $error("framing flag lost");
  property p_fe_idle;
    !FRAMING_DETECT_SELECT && !FRAMING_ERROR_FLAG |=> !FRAMING_ERROR_FLAG;
  endproperty
  a_fe_idle: assert property (p_fe_idle) else $error("framing flag in mode use");
  property p_mode_hold;
    $past(FRAMING_DETECT_SELECT) && FRAMING_DETECT_SELECT |-> $stable(MODE_BIT_ZERO);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("mode bit moved");
  property p_tick_zero;
    (BAUD_PHASE == 16'h0000) [*3] |-> !BAUD_TICK;
  endproperty
  a_tick_zero: assert property (p_tick_zero) else $error("tick at zero phase");
  property p_tick_half;
    (BAUD_PHASE == 16'h8000) [*4] |-> BAUD_TICK != $past(BAUD_TICK);
  endproperty
  a_tick_half: assert property (p_tick_half) else $error("half phase tick wrong");
endmodule
bind umbc_uart1_cfg umbc_cfg_sva u_sva (.SYS_CLK, .RST_N, .S_AXI_BVALID, .MODE_BIT_ONE,
  .RX_DONE_FLAG, .TX_DONE_FLAG, .STOP_BIT_INVALID, .MODE_BIT_ZERO, .FRAMING_DETECT_SELECT,
  .BAUD_DIVIDER_SELECT, .FRAMING_ERROR_FLAG, .SERIAL_IRQ_REQ, .BAUD_PHASE, .BAUD_TICK,
  .BIT_RATE_EN);

// ===== verif/umbc_serial_peer.sv
// behavioural far-side serial peer driving the flags and the stop-bit report
`timescale 1ns/1ps
module umbc_serial_peer (
  input wire logic clk,
  output logic mode_one,
  output logic rx_done,
  output logic tx_done,
  output logic bad_stop
);
  initial begin
    mode_one = 1'h0;
    rx_done = 1'h0;
    tx_done = 1'h0;
    bad_stop = 1'h0;
  end
  task automatic flags(input logic m, r, t);
    mode_one <= m;
    rx_done <= r;
    tx_done <= t;
    @(posedge clk);
  endtask
  // invalid stop bit reported as a one-cycle pulse
  task automatic bad_frame();
    bad_stop <= 1'h1;
    @(posedge clk);
    bad_stop <= 1'h0;
    @(posedge clk);
  endtask
endmodule
